// [pscd_capture.sv]
`timescale 1ns/100ps
module pscd_capture (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_capture,
  pscd_strap_if.dst sp,
  output logic [9:0] o_codes,
  output logic o_valid,
  output logic o_bad
);
  logic [9:0] codes_r;
  logic [9:0] codes_nxt;
  logic valid_r;
  logic valid_nxt;
  logic bad_r;
  logic bad_nxt;

  // ****************************************************************
  // One-shot strap latch
  // ****************************************************************
  always_comb begin
    codes_nxt = codes_r;
    valid_nxt = valid_r;
    bad_nxt = bad_r;
    if (i_capture && !valid_r) begin
      codes_nxt = {sp.mode, sp.divider, sp.in_type, sp.edge_rate, sp.out_type};
      valid_nxt = 1'b1;
      bad_nxt = (sp.mode == pscd_pkg::TRI_BAD) || (sp.divider == pscd_pkg::TRI_BAD)
        || (sp.in_type == pscd_pkg::TRI_BAD) || (sp.edge_rate == pscd_pkg::TRI_BAD)
        || (sp.out_type == pscd_pkg::TRI_BAD);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      codes_r <= 10'h2aa;
      valid_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      codes_r <= codes_nxt;
      valid_r <= valid_nxt;
      bad_r <= bad_nxt;
    end
  end

  assign o_codes = codes_r;
  assign o_valid = valid_r;
  assign o_bad = bad_r;
endmodule // pscd_capture

// [pscd_pkg.sv]
package pscd_pkg;

  // ****************************************************************
  // Three-state strap codes
  // ****************************************************************
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_HIGH = 2'h1;
  localparam logic [1:0] TRI_OPEN = 2'h2;
  localparam logic [1:0] TRI_BAD = 2'h3;

  // ****************************************************************
  // Setting encodings
  // ****************************************************************
  localparam logic [1:0] BUF_LVDS = 2'h0;
  localparam logic [1:0] BUF_HCSL = 2'h1;
  localparam logic [1:0] BUF_LVCMOS = 2'h2;
  localparam logic [1:0] RATE_SLOW = 2'h0;
  localparam logic [1:0] RATE_MED = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_8 = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SYNC_STAGES = 2;
  localparam int SETTLE_CYC = 4;
  localparam int CNT_W = 3;
  localparam int PIN_W = 14;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_HOST_CFG = 8'h04;
  localparam logic [7:0] REG_LIVE = 8'h08;
  localparam int HC_OTYPE_LSB = 0;
  localparam int HC_RATE_LSB = 2;
  localparam int HC_ITYPE_LSB = 4;
  localparam int HC_DIV_LSB = 6;
  localparam int HC_OE_BIT = 8;
  localparam int HC_INPUT_SELECT_PIN_LSB = 9;
  localparam int HC_INPUT_SELECT_PIN_REG_BIT = 11;
  localparam int HC_W = 12;
  localparam logic [HC_W-1:0] HOST_CFG_RST = 12'h42a;
  localparam int ST_CODES_LSB = 0;
  localparam int ST_VALID_BIT = 16;
  localparam int ST_HOST_BIT = 17;
  localparam int ST_BAD_BIT = 18;
  localparam int LV_OE_LSB = 0;
  localparam int LV_INPUT_SELECT_PIN_LSB = 2;
  localparam int LV_EN_BIT = 4;
  localparam int LV_FIRST_BIT = 5;
  localparam int LV_SECOND_BIT = 6;
  localparam int LV_AUTO_BIT = 7;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_SETTLE,
    ST_RUN
  } pscd_state_e;

endpackage

// [pscd_strap_if.sv]
`timescale 1ns/100ps
interface pscd_strap_if;
  logic [1:0] out_type;
  logic [1:0] edge_rate;
  logic [1:0] in_type;
  logic [1:0] divider;
  logic [1:0] input_select_pin;
  logic [1:0] oe;
  logic [1:0] mode;
  modport src (output out_type, edge_rate, in_type, divider, input_select_pin, oe, mode);
  modport dst (input out_type, edge_rate, in_type, divider, input_select_pin, oe, mode);
endinterface

// [pscd_strap_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// Board strap drive model
// ****************************************************************
module pscd_strap_model (
  input wire logic i_clk,
  input wire logic [13:0] i_want,
  output logic [13:0] o_pins
);
  // Levels change just after an edge, as board logic would
  always_ff @(posedge i_clk) begin
    o_pins <= i_want;
    if (i_want[11:10] != pscd_pkg::TRI_HIGH) begin
      o_pins[11:10] <= pscd_pkg::TRI_LOW;
    end
  end
endmodule // pscd_strap_model

// [pscd_sync.sv]
`timescale 1ns/100ps
module pscd_sync #(
  parameter int W = pscd_pkg::PIN_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_pins,
  pscd_strap_if.src sp
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  if (W != pscd_pkg::PIN_W) begin : g_bad_width
    $error("pscd_sync: width must match pin bundle");
  end

  // ****************************************************************
  // Two-flop synchroniser per pin bit
  // ****************************************************************
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        meta_r[g] <= 1'b0;
        sync_r[g] <= 1'b0;
      end else begin
        meta_r[g] <= i_pins[g];
        sync_r[g] <= meta_r[g];
      end
    end
  end

  assign sp.out_type = sync_r[1:0];
  assign sp.edge_rate = sync_r[3:2];
  assign sp.in_type = sync_r[5:4];
  assign sp.divider = sync_r[7:6];
  assign sp.input_select_pin = sync_r[9:8];
  assign sp.oe = sync_r[11:10];
  assign sp.mode = sync_r[13:12];
endmodule // pscd_sync

// [pscd_top.sv]
// Operation
// - Latch straps once after power-up
// - Follow select and enable pins continuously; host mode takes enable from host config, and select too when overridden
// - Resolve straps into low, high, open
// - Output type: low LVDS, high HCSL, open LVCMOS
// - Edge rate: low slow, high medium, open fast
// - Drive behaviour depends on type and rate
// - Enable low disables to high impedance
// - Input type: low LVDS, high HCSL, open LVCMOS
// - Divider: low /2, high /4, open /1
// - Divide by eight only from host settings
// - Select: low first, high second, open auto
// - Mode read after reset; open is pin mode
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module pscd_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_output_type_strap,
  input wire logic [1:0] i_edge_rate_strap,
  input wire logic [1:0] i_input_type_strap,
  input wire logic [1:0] i_divider_strap,
  input wire logic [1:0] i_input_select_pin,
  input wire logic [1:0] i_oe_pin,
  input wire logic [1:0] i_mode_pin,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_output_type,
  output logic [1:0] o_edge_rate,
  output logic [3:0] o_drive_code,
  output logic o_outputs_enabled,
  output logic o_outputs_hiz,
  output logic [1:0] o_input_type,
  output logic [1:0] o_second_input_divider,
  output logic o_first_clock_input_on,
  output logic o_second_clock_input_on,
  output logic o_auto_select,
  output logic o_config_valid,
  output logic o_host_mode
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [1:0] tri_sel(input logic [1:0] code, input logic [1:0] lo_v,
                                         input logic [1:0] hi_v, input logic [1:0] op_v);
    logic [1:0] r;
    r = op_v;
    if (code == pscd_pkg::TRI_LOW) r = lo_v;
    else if (code == pscd_pkg::TRI_HIGH) r = hi_v;
    return r;
  endfunction

  function automatic logic [1:0] sat_field(input logic [1:0] v, input logic [1:0] dflt);
    return (v == 2'h3) ? dflt : v;
  endfunction

  function automatic logic [3:0] drive_of(input logic [1:0] typ, input logic [1:0] rate);
    return {typ, rate};
  endfunction

  // ****************************************************************
  // Pin synchronisers and strap latch
  // ****************************************************************
  pscd_strap_if u_if ();

  logic capture;
  logic [9:0] cap_codes;
  logic cap_valid;
  logic cap_bad;

  pscd_sync #(
    .W(pscd_pkg::PIN_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pins({i_mode_pin, i_oe_pin, i_input_select_pin, i_divider_strap,
             i_input_type_strap, i_edge_rate_strap, i_output_type_strap}),
    .sp(u_if.src)
  );

  pscd_capture u_cap (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_capture(capture),
    .sp(u_if.dst),
    .o_codes(cap_codes),
    .o_valid(cap_valid),
    .o_bad(cap_bad)
  );

  logic [1:0] cap_ot;
  logic [1:0] cap_rate;
  logic [1:0] cap_it;
  logic [1:0] cap_div;
  logic [1:0] cap_mode;
  logic host;
  assign cap_ot = cap_codes[1:0];
  assign cap_rate = cap_codes[3:2];
  assign cap_it = cap_codes[5:4];
  assign cap_div = cap_codes[7:6];
  assign cap_mode = cap_codes[9:8];
  assign host = cap_valid && (cap_mode != pscd_pkg::TRI_OPEN);

  // ****************************************************************
  // Power-up sequence
  // ****************************************************************
  pscd_pkg::pscd_state_e st_r;
  pscd_pkg::pscd_state_e st_nxt;
  logic [pscd_pkg::CNT_W-1:0] cnt_r;
  logic [pscd_pkg::CNT_W-1:0] cnt_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    capture = 1'b0;
    unique case (st_r)
      pscd_pkg::ST_HOLD: begin
        st_nxt = pscd_pkg::ST_SETTLE;
        cnt_nxt = '0;
      end
      pscd_pkg::ST_SETTLE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == pscd_pkg::CNT_W'(pscd_pkg::SETTLE_CYC - 1)) begin
          capture = 1'b1;
          st_nxt = pscd_pkg::ST_RUN;
        end
      end
      pscd_pkg::ST_RUN: begin
        st_nxt = pscd_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= pscd_pkg::ST_HOLD;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [pscd_pkg::HC_W-1:0] hcfg_r;
  logic [pscd_pkg::HC_W-1:0] hcfg_nxt;
  logic [31:0] status_w;
  logic [31:0] live_w;
  logic req;

  assign req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_r;

  always_comb begin
    status_w = '0;
    status_w[pscd_pkg::ST_CODES_LSB +: 10] = cap_codes;
    status_w[pscd_pkg::ST_VALID_BIT] = cap_valid;
    status_w[pscd_pkg::ST_HOST_BIT] = host;
    status_w[pscd_pkg::ST_BAD_BIT] = cap_bad;
    live_w = '0;
    live_w[pscd_pkg::LV_OE_LSB +: 2] = u_if.oe;
    live_w[pscd_pkg::LV_INPUT_SELECT_PIN_LSB +: 2] = u_if.input_select_pin;
    live_w[pscd_pkg::LV_EN_BIT] = o_outputs_enabled;
    live_w[pscd_pkg::LV_FIRST_BIT] = o_first_clock_input_on;
    live_w[pscd_pkg::LV_SECOND_BIT] = o_second_clock_input_on;
    live_w[pscd_pkg::LV_AUTO_BIT] = o_auto_select;
  end

  always_comb begin
    ack_nxt = req && !ack_r;
    rdata_nxt = rdata_r;
    hcfg_nxt = hcfg_r;
    if (i_avs_read && !ack_r) begin
      unique case (i_avs_address)
        pscd_pkg::REG_STATUS: rdata_nxt = status_w;
        pscd_pkg::REG_HOST_CFG: rdata_nxt = {20'h0, hcfg_r};
        pscd_pkg::REG_LIVE: rdata_nxt = live_w;
        default: rdata_nxt = 32'h0;
      endcase
    end
    if (i_avs_write && ack_r && i_avs_address == pscd_pkg::REG_HOST_CFG) begin
      if (i_avs_byteenable[0]) hcfg_nxt[7:0] = i_avs_writedata[7:0];
      if (i_avs_byteenable[1]) hcfg_nxt[11:8] = i_avs_writedata[11:8];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      hcfg_r <= pscd_pkg::HOST_CFG_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      hcfg_r <= hcfg_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  logic [1:0] ot_r;
  logic [1:0] ot_nxt;
  logic [1:0] rate_r;
  logic [1:0] rate_nxt;
  logic [1:0] it_r;
  logic [1:0] it_nxt;
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic en_r;
  logic en_nxt;
  logic first_r;
  logic first_nxt;
  logic second_r;
  logic second_nxt;
  logic auto_r;
  logic auto_nxt;
  logic [1:0] sel_code;

  always_comb begin
    ot_nxt = pscd_pkg::BUF_LVCMOS;
    rate_nxt = pscd_pkg::RATE_FAST;
    it_nxt = pscd_pkg::BUF_LVCMOS;
    div_nxt = pscd_pkg::DIV_1;
    en_nxt = 1'b0;
    sel_code = u_if.input_select_pin;
    if (host) begin
      ot_nxt = sat_field(hcfg_r[pscd_pkg::HC_OTYPE_LSB +: 2], pscd_pkg::BUF_LVCMOS);
      rate_nxt = sat_field(hcfg_r[pscd_pkg::HC_RATE_LSB +: 2], pscd_pkg::RATE_FAST);
      it_nxt = sat_field(hcfg_r[pscd_pkg::HC_ITYPE_LSB +: 2], pscd_pkg::BUF_LVCMOS);
      div_nxt = hcfg_r[pscd_pkg::HC_DIV_LSB +: 2];
      en_nxt = hcfg_r[pscd_pkg::HC_OE_BIT];
      if (hcfg_r[pscd_pkg::HC_INPUT_SELECT_PIN_REG_BIT]) begin
        sel_code = hcfg_r[pscd_pkg::HC_INPUT_SELECT_PIN_LSB +: 2];
      end
    end else if (cap_valid) begin
      ot_nxt = tri_sel(cap_ot, pscd_pkg::BUF_LVDS, pscd_pkg::BUF_HCSL,
                       pscd_pkg::BUF_LVCMOS);
      rate_nxt = tri_sel(cap_rate, pscd_pkg::RATE_SLOW, pscd_pkg::RATE_MED,
                         pscd_pkg::RATE_FAST);
      it_nxt = tri_sel(cap_it, pscd_pkg::BUF_LVDS, pscd_pkg::BUF_HCSL,
                       pscd_pkg::BUF_LVCMOS);
      div_nxt = tri_sel(cap_div, pscd_pkg::DIV_2, pscd_pkg::DIV_4,
                        pscd_pkg::DIV_1);
      en_nxt = (u_if.oe == pscd_pkg::TRI_HIGH);
    end
    first_nxt = cap_valid && (sel_code == pscd_pkg::TRI_LOW);
    second_nxt = cap_valid && (sel_code == pscd_pkg::TRI_HIGH);
    auto_nxt = cap_valid && !first_nxt && !second_nxt;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ot_r <= pscd_pkg::BUF_LVCMOS;
      rate_r <= pscd_pkg::RATE_FAST;
      it_r <= pscd_pkg::BUF_LVCMOS;
      div_r <= pscd_pkg::DIV_1;
      en_r <= 1'b0;
      first_r <= 1'b0;
      second_r <= 1'b0;
      auto_r <= 1'b0;
    end else begin
      ot_r <= ot_nxt;
      rate_r <= rate_nxt;
      it_r <= it_nxt;
      div_r <= div_nxt;
      en_r <= en_nxt;
      first_r <= first_nxt;
      second_r <= second_nxt;
      auto_r <= auto_nxt;
    end
  end

  assign o_output_type = ot_r;
  assign o_edge_rate = rate_r;
  assign o_drive_code = drive_of(ot_r, rate_r);
  assign o_outputs_enabled = en_r;
  assign o_outputs_hiz = !en_r;
  assign o_input_type = it_r;
  assign o_second_input_divider = div_r;
  assign o_first_clock_input_on = first_r;
  assign o_second_clock_input_on = second_r;
  assign o_auto_select = auto_r;
  assign o_config_valid = cap_valid;
  assign o_host_mode = host;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic pin_run;
  assign pin_run = cap_valid && !host;

  a_capture_once: assert property (cap_valid && $past(cap_valid) |-> $stable(cap_codes))
    else $error("captured straps changed");
  a_oe_high_on: assert property (pin_run && u_if.oe == pscd_pkg::TRI_HIGH
    |=> o_outputs_enabled && !o_outputs_hiz)
    else $error("enable pin high not followed");
  a_oe_low_hiz: assert property (pin_run && u_if.oe != pscd_pkg::TRI_HIGH
    |=> !o_outputs_enabled && o_outputs_hiz)
    else $error("outputs not high impedance");
  a_type_decode: assert property (pin_run && $past(pin_run)
    |-> o_output_type == tri_sel(cap_ot, pscd_pkg::BUF_LVDS, pscd_pkg::BUF_HCSL,
                                 pscd_pkg::BUF_LVCMOS))
    else $error("output type wrong");
  a_rate_open_fast: assert property (pin_run && cap_rate == pscd_pkg::TRI_OPEN
    |=> o_edge_rate == pscd_pkg::RATE_FAST)
    else $error("open edge strap not fast");
  a_drive_follows: assert property (host && $changed(o_output_type) && $stable(o_edge_rate)
    |-> $changed(o_drive_code))
    else $error("drive did not track type");
  a_intype_low: assert property (pin_run && cap_it == pscd_pkg::TRI_LOW
    |=> o_input_type == pscd_pkg::BUF_LVDS)
    else $error("input type low not LVDS");
  a_div_high_four: assert property (pin_run && cap_div == pscd_pkg::TRI_HIGH
    |=> o_second_input_divider == pscd_pkg::DIV_4)
    else $error("divider high not four");
  a_pin_no_eight: assert property (pin_run |=> o_second_input_divider != pscd_pkg::DIV_8)
    else $error("divide by eight in pin mode");
  a_input_select_pin_open_auto: assert property (pin_run && u_if.input_select_pin == pscd_pkg::TRI_OPEN
    |=> o_auto_select && !o_first_clock_input_on && !o_second_clock_input_on)
    else $error("open select not automatic");
  a_mode_capture: assert property (capture |=> cap_valid
    && (o_host_mode == ($past(u_if.mode) != pscd_pkg::TRI_OPEN)))
    else $error("mode not taken at capture");
  a_bad_flagged: assert property (capture && u_if.out_type == pscd_pkg::TRI_BAD
    |=> cap_bad ##1 o_output_type == pscd_pkg::BUF_LVCMOS || host)
    else $error("invalid code not handled");
  a_bus_answer: assert property (req |-> ##[0:1] !o_avs_waitrequest)
    else $error("bus answer late");

  c_pin_mode: cover property (capture ##1 !host);
  c_host_mode: cover property (capture ##1 host);
  c_auto_sel: cover property (pin_run && o_auto_select);
  c_oe_toggle: cover property (pin_run && $rose(o_outputs_enabled));

endmodule // pscd_top

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [13:0] want = 14'h2000;
  logic [13:0] pins;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic wait_r;
  logic [1:0] otype, rate, itype, div;
  logic [3:0] drive;
  logic en, hiz, first, second, auto_s, valid, host;
  int num_errors = 0;
  int check_count = 0;

  always #5 i_clk = ~i_clk;

  pscd_strap_model model (.i_clk(i_clk), .i_want(want), .o_pins(pins));

  pscd_top uut (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_output_type_strap(pins[1:0]), .i_edge_rate_strap(pins[3:2]),
    .i_input_type_strap(pins[5:4]), .i_divider_strap(pins[7:6]),
    .i_input_select_pin(pins[9:8]), .i_oe_pin(pins[11:10]), .i_mode_pin(pins[13:12]),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'h3), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
    .o_output_type(otype), .o_edge_rate(rate), .o_drive_code(drive),
    .o_outputs_enabled(en), .o_outputs_hiz(hiz), .o_input_type(itype),
    .o_second_input_divider(div), .o_first_clock_input_on(first),
    .o_second_clock_input_on(second), .o_auto_select(auto_s),
    .o_config_valid(valid), .o_host_mode(host)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [1:0] tri_map(input logic [1:0] c, input logic [1:0] lo,
                                         input logic [1:0] hi, input logic [1:0] op);
    case (c)
      pscd_pkg::TRI_LOW: return lo;
      pscd_pkg::TRI_HIGH: return hi;
      default: return op;
    endcase
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    #1;
    while (wait_r !== 1'b0 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      chk("bus answer", 0, 1);
    end
    @(posedge i_clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic do_reset(input logic [13:0] straps);
    int n;
    @(posedge i_clk);
    want <= straps;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    n = 0;
    #1;
    while (valid !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("config valid", 1, valid);
    @(posedge i_clk);
    #1;
  endtask

  task automatic wait_en(input logic e);
    int n;
    n = 0;
    while (en !== e && n < 10) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_capture();
    logic [1:0] k, eo, er;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      do_reset({pscd_pkg::TRI_OPEN, 4'h4, k, k, k, k});
      eo = tri_map(k, pscd_pkg::BUF_LVDS, pscd_pkg::BUF_HCSL, pscd_pkg::BUF_LVCMOS);
      er = tri_map(k, pscd_pkg::RATE_SLOW, pscd_pkg::RATE_MED, pscd_pkg::RATE_FAST);
      chk("output type", eo, otype);
      chk("edge rate", er, rate);
      chk("drive code", {eo, er}, drive);
      chk("input type", eo, itype);
      chk("divider", tri_map(k, pscd_pkg::DIV_2, pscd_pkg::DIV_4, pscd_pkg::DIV_1), div);
      chk("host mode", 0, host);
      bus(1'b0, pscd_pkg::REG_STATUS, 32'h0, got);
      chk("status codes", {pscd_pkg::TRI_OPEN, k, k, k, k}, got[9:0]);
      chk("status bad", (i == 3), got[18]);
      @(posedge i_clk);
      want[7:0] <= ~want[7:0];
      repeat (6) @(posedge i_clk);
      #1;
      chk("latched type", eo, otype);
      chk("latched div", tri_map(k, pscd_pkg::DIV_2, pscd_pkg::DIV_4, pscd_pkg::DIV_1), div);
    end
  endtask

  task automatic test_live();
    do_reset({pscd_pkg::TRI_OPEN, 12'h0});
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      want[11:10] <= (i % 2) ? pscd_pkg::TRI_HIGH : pscd_pkg::TRI_LOW;
      wait_en(i % 2);
      chk("enabled", i % 2, en);
      chk("high impedance", !(i % 2), hiz);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      want[9:8] <= 2'(i);
      repeat (4) @(posedge i_clk);
      #1;
      chk("first input", i == 0, first);
      chk("second input", i == 1, second);
      chk("auto select", i == 2, auto_s);
    end
    bus(1'b1, pscd_pkg::REG_HOST_CFG, 32'h1c0, got);
    repeat (2) @(posedge i_clk);
    #1;
    chk("pin mode divider", pscd_pkg::DIV_2, div);
    bus(1'b0, pscd_pkg::REG_LIVE, 32'h0, got);
    chk("live status", 32'h99, got);
  endtask

  task automatic test_host();
    do_reset({pscd_pkg::TRI_LOW, 12'h0});
    chk("host mode", 1, host);
    bus(1'b1, pscd_pkg::REG_HOST_CFG, 32'hbc8, got);
    repeat (2) @(posedge i_clk);
    #1;
    chk("host divider", pscd_pkg::DIV_8, div);
    chk("host enabled", 1, en);
    chk("host type", pscd_pkg::BUF_LVDS, otype);
    chk("host drive", {pscd_pkg::BUF_LVDS, pscd_pkg::RATE_FAST}, drive);
    chk("host second", 1, second);
    bus(1'b0, pscd_pkg::REG_HOST_CFG, 32'h0, got);
    chk("host cfg readback", 32'hbc8, got);
    bus(1'b0, 8'h10, 32'h0, got);
    chk("unmapped read", 32'h0, got);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    test_capture();
    test_live();
    test_host();
    summarize();
  end

  initial begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule // testbench
